// ==== include/pnpg_pkg.sv ====
package pnpg_pkg;

    // Bus geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int REG_W = 16;
    localparam int NUM_PAIRS = 4;

    // Byte address = 4 * index; index = {port nibble, register index}
    localparam int IDX_LSB = 2;
    localparam int REG_IDX_W = 12;
    localparam int PORT_LSB = IDX_LSB + REG_IDX_W;
    localparam int PORT_W = 4;
    localparam logic [11:0] IDX_LOCAL_NP = 12'h10e;
    localparam logic [11:0] IDX_PARTNER_NP = 12'h110;
    localparam logic [11:0] IDX_GIG_CTRL = 12'h112;
    localparam logic [3:0] PORT_FIRST = 4'h1;

    // Next-page word fields
    localparam int NP_MORE_BIT = 15;
    localparam int NP_ACK_BIT = 14;
    localparam int NP_MSG_BIT = 13;
    localparam int NP_ACK2_BIT = 12;
    localparam int NP_TOGGLE_BIT = 11;

    // Gigabit control fields
    localparam int GC_TEST_LSB = 13;
    localparam int GC_TEST_W = 3;
    localparam int GC_MS_MANUAL_BIT = 12;
    localparam int GC_MS_VALUE_BIT = 11;
    localparam int GC_PORT_TYPE_BIT = 10;
    localparam int GC_ADV_FD_BIT = 9;
    localparam int GC_ADV_HD_BIT = 8;

    // Reset values and writable-bit masks
    localparam logic [15:0] LOCAL_NP_RESET = 16'h2001;
    localparam logic [15:0] LOCAL_NP_WMASK = 16'hb7ff;
    localparam logic [15:0] PARTNER_NP_RESET = 16'h0000;
    localparam logic [15:0] GIG_CTRL_RESET = 16'h0600;
    localparam logic [15:0] GIG_CTRL_WMASK = 16'hff00;

    // Transmitter test codes
    localparam logic [2:0] TEST_NORMAL = 3'h0;
    localparam logic [2:0] TEST_LAST = 3'h4;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== logic/pnpg_axil.sv ====
module pnpg_axil (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write address and data
    input wire logic [pnpg_pkg::ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [pnpg_pkg::DATA_W-1:0] s_wdata,
    input wire logic [pnpg_pkg::STRB_W-1:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // Write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // Read address and data
    input wire logic [pnpg_pkg::ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [pnpg_pkg::DATA_W-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Register file side
    output logic wr_en,
    output logic [pnpg_pkg::ADDR_W-1:0] wr_addr,
    output logic [pnpg_pkg::DATA_W-1:0] wr_data,
    output logic [pnpg_pkg::STRB_W-1:0] wr_strb,
    input wire logic wr_ok,
    input wire logic [pnpg_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_ok
);
    import pnpg_pkg::*;

    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } pnpg_axil_st_t;

    pnpg_axil_st_t s_reg;
    pnpg_axil_st_t s_next;

    // Write fires once address and data are both held
    assign wr_en = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
    assign wr_addr = s_reg.awaddr;
    assign wr_data = s_reg.wdata;
    assign wr_strb = s_reg.wstrb;

    // Handshake state
    always_comb begin
        s_next = s_reg;
        if (s_awvalid && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.awaddr = s_awaddr;
        end
        if (s_wvalid && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata = s_wdata;
            s_next.wstrb = s_wstrb;
        end
        if (s_reg.bvalid && s_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (wr_en) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_reg.rvalid && s_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_ok ? rd_data : '0;
            s_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        s_next.awready = ~s_next.aw_held & ~s_next.bvalid;
        s_next.wready = ~s_next.w_held & ~s_next.bvalid;
        s_next.arready = ~s_next.rvalid;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_awready = s_reg.awready;
    assign s_wready = s_reg.wready;
    assign s_bvalid = s_reg.bvalid;
    assign s_bresp = s_reg.bresp;
    assign s_arready = s_reg.arready;
    assign s_rvalid = s_reg.rvalid;
    assign s_rdata = s_reg.rdata;
    assign s_rresp = s_reg.rresp;

endmodule // pnpg_axil

// ==== logic/pnpg_regs.sv ====
module pnpg_regs #(
    parameter int NUM_PORTS = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite write address and data
    input wire logic [pnpg_pkg::ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [pnpg_pkg::DATA_W-1:0] s_wdata,
    input wire logic [pnpg_pkg::STRB_W-1:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // AXI4-Lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [pnpg_pkg::ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [pnpg_pkg::DATA_W-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // From the negotiation engine, per port
    input wire logic [NUM_PORTS-1:0] an_tx_toggle,
    input wire logic [NUM_PORTS-1:0] an_rx_valid,
    input wire logic [NUM_PORTS-1:0][pnpg_pkg::REG_W-1:0] an_rx_page,
    // To the negotiation engine and transmitter, per port
    output logic [NUM_PORTS-1:0][pnpg_pkg::REG_W-1:0] np_tx_word,
    output logic [NUM_PORTS-1:0][pnpg_pkg::GC_TEST_W-1:0] test_code,
    output logic [NUM_PORTS-1:0][pnpg_pkg::NUM_PAIRS-1:0] test_pair_en,
    output logic [NUM_PORTS-1:0] ms_manual_en,
    output logic [NUM_PORTS-1:0] ms_force_master,
    output logic [NUM_PORTS-1:0] ms_prefer_master,
    output logic [NUM_PORTS-1:0] adv_1000_fd,
    output logic [NUM_PORTS-1:0] adv_1000_hd
);
    import pnpg_pkg::*;

    typedef struct packed {
        logic [NUM_PORTS-1:0][REG_W-1:0] local_np;
        logic [NUM_PORTS-1:0][REG_W-1:0] partner_np;
        logic [NUM_PORTS-1:0][REG_W-1:0] gig_ctrl;
        logic [NUM_PORTS-1:0][NUM_PAIRS-1:0] pair_en;
        logic [NUM_PORTS-1:0] force_master;
        logic [NUM_PORTS-1:0] prefer_master;
    } pnpg_regs_st_t;

    pnpg_regs_st_t s_reg;
    pnpg_regs_st_t s_next;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [STRB_W-1:0] wr_strb;
    logic wr_ok;
    logic [DATA_W-1:0] rd_data;
    logic rd_ok;
    logic [REG_W-1:0] wr_mask;

    // Reset release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Port nibble check: ports start at one
    function automatic logic port_hit(input logic [ADDR_W-1:0] a);
        logic [PORT_W-1:0] pn;
        pn = a[PORT_LSB +: PORT_W];
        port_hit = (a[IDX_LSB-1:0] == '0) && (pn >= PORT_FIRST)
            && ({1'b0, pn} <= (PORT_W + 1)'(NUM_PORTS));
    endfunction

    // Mapped register index at this address
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        logic [REG_IDX_W-1:0] ri;
        ri = a[IDX_LSB +: REG_IDX_W];
        reg_hit = (ri == IDX_LOCAL_NP) || (ri == IDX_PARTNER_NP) || (ri == IDX_GIG_CTRL);
    endfunction

    // Bus front end
    pnpg_axil u_axil (
        .clk(clk),
        .rst_n(rst_n),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Address decode and lane mask
    assign wr_ok = port_hit(wr_addr) && reg_hit(wr_addr);
    assign rd_ok = port_hit(s_araddr) && reg_hit(s_araddr);
    assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // Read multiplexer, upper half reads zero
    always_comb begin
        logic [PORT_W-1:0] rp;
        logic [REG_IDX_W-1:0] ri;
        rp = s_araddr[PORT_LSB +: PORT_W] - PORT_FIRST;
        ri = s_araddr[IDX_LSB +: REG_IDX_W];
        rd_data = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (rp == PORT_W'(p)) begin
                unique case (ri)
                    IDX_LOCAL_NP: rd_data[REG_W-1:0] = s_reg.local_np[p];
                    IDX_PARTNER_NP: rd_data[REG_W-1:0] = s_reg.partner_np[p];
                    IDX_GIG_CTRL: rd_data[REG_W-1:0] = s_reg.gig_ctrl[p];
                    default: rd_data = '0;
                endcase
            end
        end
    end

    // Register updates and derived controls
    always_comb begin
        logic [PORT_W-1:0] wp;
        logic [REG_IDX_W-1:0] wi;
        logic [GC_TEST_W-1:0] code;
        logic manual;
        wp = wr_addr[PORT_LSB +: PORT_W] - PORT_FIRST;
        wi = wr_addr[IDX_LSB +: REG_IDX_W];
        code = '0;
        manual = 1'b0;
        s_next = s_reg;
        for (int p = 0; p < NUM_PORTS; p++) begin
            // Toggle of the last transmitted word
            s_next.local_np[p][NP_TOGGLE_BIT] = an_tx_toggle[p];
            // Capture partner page; toggle bit reads the inverse of an_tx_toggle
            if (an_rx_valid[p]) begin
                s_next.partner_np[p] = an_rx_page[p];
                s_next.partner_np[p][NP_TOGGLE_BIT] = ~an_tx_toggle[p];
            end
            // Software writes to writable bits only
            if (wr_en && wr_ok && (wp == PORT_W'(p))) begin
                if (wi == IDX_LOCAL_NP) begin
                    s_next.local_np[p] = (s_next.local_np[p] & ~(LOCAL_NP_WMASK & wr_mask))
                        | (wr_data[REG_W-1:0] & LOCAL_NP_WMASK & wr_mask);
                end
                if (wi == IDX_GIG_CTRL) begin
                    s_next.gig_ctrl[p] = (s_reg.gig_ctrl[p] & ~(GIG_CTRL_WMASK & wr_mask))
                        | (wr_data[REG_W-1:0] & GIG_CTRL_WMASK & wr_mask);
                end
            end
            // Test waveform on every pair for codes one to four
            code = s_next.gig_ctrl[p][GC_TEST_LSB +: GC_TEST_W];
            s_next.pair_en[p] = ((code != TEST_NORMAL) && (code <= TEST_LAST))
                ? {NUM_PAIRS{1'b1}} : {NUM_PAIRS{1'b0}};
            // Master/slave resolution inputs
            manual = s_next.gig_ctrl[p][GC_MS_MANUAL_BIT];
            s_next.force_master[p] = manual & s_next.gig_ctrl[p][GC_MS_VALUE_BIT];
            s_next.prefer_master[p] = ~manual & s_next.gig_ctrl[p][GC_PORT_TYPE_BIT];
        end
    end

    // State register with documented resets
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.local_np <= {NUM_PORTS{LOCAL_NP_RESET}};
            s_reg.partner_np <= {NUM_PORTS{PARTNER_NP_RESET}};
            s_reg.gig_ctrl <= {NUM_PORTS{GIG_CTRL_RESET}};
            s_reg.pair_en <= '0;
            s_reg.force_master <= '0;
            s_reg.prefer_master <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flops
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            np_tx_word[p] = s_reg.local_np[p];
            test_code[p] = s_reg.gig_ctrl[p][GC_TEST_LSB +: GC_TEST_W];
            test_pair_en[p] = s_reg.pair_en[p];
            ms_manual_en[p] = s_reg.gig_ctrl[p][GC_MS_MANUAL_BIT];
            ms_force_master[p] = s_reg.force_master[p];
            ms_prefer_master[p] = s_reg.prefer_master[p];
            adv_1000_fd[p] = s_reg.gig_ctrl[p][GC_ADV_FD_BIT];
            adv_1000_hd[p] = s_reg.gig_ctrl[p][GC_ADV_HD_BIT];
        end
    end

endmodule // pnpg_regs

// ==== verification/pnpg_regs_asserts.sv ====
module pnpg_regs_asserts #(
    parameter int NUM_PORTS = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus handshakes
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    // Engine and control outputs
    input wire logic [NUM_PORTS-1:0] an_tx_toggle,
    input wire logic [NUM_PORTS-1:0][pnpg_pkg::REG_W-1:0] np_tx_word,
    input wire logic [NUM_PORTS-1:0][pnpg_pkg::GC_TEST_W-1:0] test_code,
    input wire logic [NUM_PORTS-1:0][pnpg_pkg::NUM_PAIRS-1:0] test_pair_en,
    input wire logic [NUM_PORTS-1:0] ms_manual_en,
    input wire logic [NUM_PORTS-1:0] ms_force_master,
    input wire logic [NUM_PORTS-1:0] ms_prefer_master,
    input wire logic [NUM_PORTS-1:0] adv_1000_fd,
    input wire logic [NUM_PORTS-1:0] adv_1000_hd
);
    timeunit 1ns;
    timeprecision 1ps;
    import pnpg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [1:0] up_cnt;
    // Cycles since reset release, saturating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    a_reset_word: assert property (
        $rose(reset_n) |-> np_tx_word[0] == 16'h2001) else $error("local word not reset");
    a_reset_gig: assert property (
        $rose(reset_n) |-> test_code[0] == 3'h0 && !ms_manual_en[0] && ms_prefer_master[0]
        && adv_1000_fd[0] && !adv_1000_hd[0]) else $error("gigabit control not reset");
    a_local_toggle: assert property (
        up_cnt == 2'h3 |-> np_tx_word[0][NP_TOGGLE_BIT] == $past(an_tx_toggle[0]))
        else $error("local toggle does not follow engine");
    a_ack_reserved: assert property (
        np_tx_word[0][NP_ACK_BIT] == 1'h0) else $error("reserved local bit set");
    a_pairs_on: assert property (
        test_code[0] inside {[3'h1:3'h4]} && $stable(test_code[0]) |-> test_pair_en[0] == 4'hf)
        else $error("test mode not on all pairs");
    a_pairs_off: assert property (
        !(test_code[0] inside {[3'h1:3'h4]}) && $stable(test_code[0]) |-> test_pair_en[0] == 4'h0)
        else $error("pairs driven without test mode");
    a_force_manual: assert property (
        ms_force_master[0] |-> ms_manual_en[0]) else $error("forced master without manual");
    a_prefer_auto: assert property (
        ms_prefer_master[0] |-> !ms_manual_en[0]) else $error("preference used in manual");
    a_read_answer: assert property (
        s_arvalid && s_arready |=> s_rvalid) else $error("read answer late");
    c_test_on: cover property (test_pair_en[0] == 4'hf);
    c_manual: cover property (ms_force_master[0]);
    c_write: cover property (s_bvalid && s_bready);
endmodule // pnpg_regs_asserts

// ==== verification/pnpg_partner.sv ====
module pnpg_partner #(
    parameter int NUM_PORTS = 4
) (
    // Clock
    input wire logic clk,
    // Pages exchanged with the remote side
    output logic [NUM_PORTS-1:0] an_tx_toggle,
    output logic [NUM_PORTS-1:0] an_rx_valid,
    output logic [NUM_PORTS-1:0][15:0] an_rx_page
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        an_tx_toggle = '0;
        an_rx_valid = '0;
        an_rx_page = '0;
    end
    // One received page with its toggle; the page bus is scrambled once released
    task automatic send(input int p, input logic [15:0] pg, input logic tog);
        @(posedge clk);
        an_tx_toggle[p] <= tog;
        an_rx_page[p] <= pg;
        an_rx_valid[p] <= 1'h1;
        @(posedge clk);
        an_rx_valid[p] <= 1'h0;
        an_rx_page[p] <= ~pg;
    endtask
endmodule // pnpg_partner

// ==== verification/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pnpg_pkg::*;
    localparam int NP = 4;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [ADDR_W-1:0] s_awaddr = '0, s_araddr = '0;
    logic [DATA_W-1:0] s_wdata = '0, s_rdata;
    logic [STRB_W-1:0] s_wstrb = '0;
    logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic [NP-1:0] an_tx_toggle, an_rx_valid, ms_manual_en, ms_force_master, ms_prefer_master;
    logic [NP-1:0] adv_1000_fd, adv_1000_hd;
    logic [NP-1:0][REG_W-1:0] an_rx_page, np_tx_word;
    logic [NP-1:0][GC_TEST_W-1:0] test_code;
    logic [NP-1:0][NUM_PAIRS-1:0] test_pair_en;
    logic [15:0] msv [5] = '{16'h1800, 16'h1000, 16'h0c00, 16'h0300, 16'hffff};
    logic [4:0] mse [5] = '{5'h18, 5'h10, 5'h04, 5'h03, 5'h1b};
    logic [ADDR_W-1:0] bad [4] = '{18'h00438, 18'h14438, 18'h04444, 18'h0444a};
    int err_count = 0, check_count = 0;
    initial forever #4 clk = ~clk;
    pnpg_regs #(.NUM_PORTS(NP)) pnpg_regs_inst (.clk(clk), .reset_n(reset_n),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .an_tx_toggle(an_tx_toggle), .an_rx_valid(an_rx_valid),
        .an_rx_page(an_rx_page), .np_tx_word(np_tx_word), .test_code(test_code),
        .test_pair_en(test_pair_en), .ms_manual_en(ms_manual_en),
        .ms_force_master(ms_force_master), .ms_prefer_master(ms_prefer_master),
        .adv_1000_fd(adv_1000_fd), .adv_1000_hd(adv_1000_hd));
    pnpg_partner #(.NUM_PORTS(NP)) pnpg_partner_inst (.clk(clk), .an_tx_toggle(an_tx_toggle),
        .an_rx_valid(an_rx_valid), .an_rx_page(an_rx_page));
    function automatic logic [ADDR_W-1:0] ra(input logic [3:0] p, input logic [11:0] i);
        return {p, i, 2'h0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus write: address and data offered together, each dropped once taken
    task automatic wc(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hf;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        s_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'h0;
            if (s_wready) s_wvalid <= 1'h0;
        end while (s_bvalid !== 1'h1);
        s_bready <= 1'h0;
        chk({30'h0, s_bresp}, {30'h0, er});
    endtask
    // Bus read compared with expected data and response
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'h1;
        s_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'h0;
        end while (s_rvalid !== 1'h1);
        s_rready <= 1'h0;
        chk(s_rdata, e);
        chk({30'h0, s_rresp}, {30'h0, er});
    endtask
    task automatic test_done();
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        for (int p = 1; p <= 4; p++) begin
            rc(ra(p[3:0], IDX_LOCAL_NP), 32'h2001, 2'h0);
            rc(ra(p[3:0], IDX_PARTNER_NP), 32'h0, 2'h0);
            rc(ra(p[3:0], IDX_GIG_CTRL), 32'h0600, 2'h0);
        end
        wc(ra(4'h1, IDX_LOCAL_NP), 32'hffff_ffff, 2'h0);
        rc(ra(4'h1, IDX_LOCAL_NP), 32'hb7ff, 2'h0);
        chk({16'h0, np_tx_word[0]}, 32'hb7ff);
        pnpg_partner_inst.send(0, 16'hdfff, 1'h1);
        rc(ra(4'h1, IDX_LOCAL_NP), 32'hbfff, 2'h0);
        rc(ra(4'h1, IDX_PARTNER_NP), 32'hd7ff, 2'h0);
        pnpg_partner_inst.send(0, 16'h0000, 1'h0);
        rc(ra(4'h1, IDX_PARTNER_NP), 32'h0800, 2'h0);
        rc(ra(4'h1, IDX_LOCAL_NP), 32'hb7ff, 2'h0);
        wc(ra(4'h1, IDX_LOCAL_NP), 32'h0, 2'h0);
        rc(ra(4'h1, IDX_LOCAL_NP), 32'h0, 2'h0);
        wc(ra(4'h1, IDX_PARTNER_NP), 32'hffff, 2'h0);
        rc(ra(4'h1, IDX_PARTNER_NP), 32'h0800, 2'h0);
        // Every test code 0 to 7 written, read back and checked on the pair enables
        for (int c = 0; c < 8; c++) begin
            wc(ra(4'h1, IDX_GIG_CTRL), {16'h0, c[2:0], 13'h0}, 2'h0);
            rc(ra(4'h1, IDX_GIG_CTRL), {16'h0, c[2:0], 13'h0}, 2'h0);
            chk({29'h0, test_code[0]}, {29'h0, c[2:0]});
            chk({28'h0, test_pair_en[0]}, (c >= 1 && c <= 4) ? 32'hf : 32'h0);
        end
        for (int i = 0; i < 5; i++) begin
            wc(ra(4'h1, IDX_GIG_CTRL), {16'h0, msv[i]}, 2'h0);
            rc(ra(4'h1, IDX_GIG_CTRL), {16'h0, msv[i] & 16'hff00}, 2'h0);
            chk({27'h0, ms_manual_en[0], ms_force_master[0], ms_prefer_master[0], adv_1000_fd[0],
                adv_1000_hd[0]}, {27'h0, mse[i]});
        end
        for (int i = 0; i < 4; i++) begin
            wc(bad[i], 32'h0, RESP_SLVERR);
            rc(bad[i], 32'h0, RESP_SLVERR);
        end
        rc(ra(4'h1, IDX_GIG_CTRL), 32'hff00, 2'h0);
        wc(ra(4'h4, IDX_GIG_CTRL), 32'h2000, 2'h0);
        rc(ra(4'h3, IDX_GIG_CTRL), 32'h0600, 2'h0);
        chk({28'h0, test_pair_en[3]}, 32'hf);
        test_done();
    end
endmodule // tb_top
bind pnpg_regs pnpg_regs_asserts #(.NUM_PORTS(NUM_PORTS)) pnpg_regs_asserts_inst (.clk(clk),
    .reset_n(reset_n), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rvalid(s_rvalid), .an_tx_toggle(an_tx_toggle),
    .np_tx_word(np_tx_word), .test_code(test_code), .test_pair_en(test_pair_en),
    .ms_manual_en(ms_manual_en), .ms_force_master(ms_force_master),
    .ms_prefer_master(ms_prefer_master), .adv_1000_fd(adv_1000_fd), .adv_1000_hd(adv_1000_hd));
